// ===== verilog/memmap_regs.svh
// Register offsets, field positions, reset values and timing counts
//
// Functional notes
// - Compatibility map: ROM A 0000-1FFF, ROM B 2000-2FFF, ROM C 3000-37FF.
// - Printer status enabled on read 37E8/37E9 in compatibility map or port F8/F9.
// - Compatibility map video RAM at 3C00-3FFF; page bit picks 1K half.
// - Compatibility map RAM 4000-7FFF for 16K, 4000-FFFF for 64K.
// - Map II: RAM, keyboard 3800-3BFF, video 3C00-3FFF, RAM above.
// - Map III: RAM 0000-F3FF, keyboard F400-F7FF, video F800-FFFF.
// - Map IV: all RAM, two 32K banks.
// - ROM enables only in compatibility map.
// - System data buffer disabled during any ROM access.
// - RAM address presented as multiplexed row and column halves.
// - 128K: column strobe only to the addressed RAM row.
// - Keyboard read drives columns from A0-A7, returns rows on D0-D7.
// - Row bit high unless key in selected column pressed.
// - Video address muxed refresh/processor; writes latched, reads buffered.
// - Video access during active display latches data and waits processor.
// - Options register ports 84-87 select map; bit 7 is video page.
`ifndef MEMMAP_REGS_SVH
`define MEMMAP_REGS_SVH

`define OFS_OPTIONS 32'h0000_0000
`define OFS_CONFIG 32'h0000_0004
`define OFS_STATUS 32'h0000_0008
`define OFS_KEYS_LO 32'h0000_000C
`define OFS_KEYS_HI 32'h0000_0010
`define OPT_RESET 8'h00
`define OPT_PAGE_BIT 7
`define OPT_FIXUP_BIT 6
`define OPT_MEM1_BIT 5
`define OPT_MEM0_BIT 4
`define OPT_SEL1_BIT 1
`define OPT_SEL0_BIT 0
`define PORT_OPT_BASE 8'h84
`define PORT_PRN_BASE 8'hF8
`define ADR_PRN0 16'h37E8
`define ADR_PRN1 16'h37E9
`define ADR_ROMA_END 16'h1FFF
`define ADR_ROMB_END 16'h2FFF
`define ADR_ROMC_END 16'h37FF
`define ADR_KBD_END 16'h3BFF
`define ADR_VID_END 16'h3FFF
`define ADR_RAM16_END 16'h7FFF
`define ADR_M3_RAM_END 16'hF3FF
`define ADR_M3_KBD_END 16'hF7FF
`define RAS_NS 10
`define RAS_CYC ((`RAS_NS + 4) / 5)
`define CAS_NS 10
`define CAS_CYC ((`CAS_NS + 4) / 5)

`endif

// ===== verilog/memmap_pkg.sv
// Types shared by the memory decoder
package memmap_pkg;
    typedef enum logic [1:0] {
        MAP_I = 2'b00,
        MAP_II = 2'b01,
        MAP_III = 2'b10,
        MAP_IV = 2'b11
    } map_type;

    typedef enum logic [1:0] {
        RSZ_16K = 2'b00,
        RSZ_64K = 2'b01,
        RSZ_128K = 2'b10
    } ramsize_type;

    typedef enum logic [3:0] {
        TGT_NONE = 4'h0,
        TGT_ROMA = 4'h1,
        TGT_ROMB = 4'h2,
        TGT_ROMC = 4'h3,
        TGT_PRN = 4'h4,
        TGT_KBD = 4'h5,
        TGT_VID = 4'h6,
        TGT_RAM = 4'h7
    } target_type;

    typedef enum logic [1:0] {
        DR_IDLE = 2'b00,
        DR_ROW = 2'b01,
        DR_COL = 2'b10
    } dram_state_type;
endpackage

// ===== verilog/mem_region_decode.sv
// Combinational address region decoder for the four memory maps
`timescale 1ns/10ps
`default_nettype none
`include "memmap_regs.svh"
module mem_region_decode (
    input wire logic [15:0] i_addr,
    input wire memmap_pkg::map_type i_map,
    input wire memmap_pkg::ramsize_type i_size,
    input wire logic i_rd,
    output memmap_pkg::target_type o_target
);
    import memmap_pkg::*;

    // Region selection per map
    always_comb begin
        o_target = TGT_NONE;
        unique case (i_map)
            MAP_I: begin
                if (i_addr <= `ADR_ROMA_END) begin
                    o_target = TGT_ROMA;
                end else if (i_addr <= `ADR_ROMB_END) begin
                    o_target = TGT_ROMB;
                end else if (i_addr == `ADR_PRN0 || i_addr == `ADR_PRN1) begin
                    o_target = i_rd ? TGT_PRN : TGT_NONE;
                end else if (i_addr <= `ADR_ROMC_END) begin
                    o_target = TGT_ROMC;
                end else if (i_addr <= `ADR_KBD_END) begin
                    o_target = TGT_KBD;
                end else if (i_addr <= `ADR_VID_END) begin
                    o_target = TGT_VID;
                end else if (i_size == RSZ_16K) begin
                    o_target = (i_addr <= `ADR_RAM16_END) ? TGT_RAM
                                                           : TGT_NONE;
                end else begin
                    o_target = TGT_RAM;
                end
            end
            MAP_II: begin
                if (i_addr <= `ADR_ROMC_END) begin
                    o_target = TGT_RAM;
                end else if (i_addr <= `ADR_KBD_END) begin
                    o_target = TGT_KBD;
                end else if (i_addr <= `ADR_VID_END) begin
                    o_target = TGT_VID;
                end else begin
                    o_target = TGT_RAM;
                end
            end
            MAP_III: begin
                if (i_addr <= `ADR_M3_RAM_END) begin
                    o_target = TGT_RAM;
                end else if (i_addr <= `ADR_M3_KBD_END) begin
                    o_target = TGT_KBD;
                end else begin
                    o_target = TGT_VID;
                end
            end
            MAP_IV: begin
                o_target = TGT_RAM;
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== verilog/memory_map_decoder.sv
// Memory-space decoder with options register, DRAM, keyboard and video
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "memmap_regs.svh"
module memory_map_decoder (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Processor memory bus
    input wire logic [15:0] i_cpu_addr,
    input wire logic [7:0] i_cpu_wdata,
    input wire logic i_cpu_mreq,
    input wire logic i_cpu_iorq,
    input wire logic i_cpu_rd,
    input wire logic i_cpu_wr,
    output logic [7:0] o_cpu_rdata,
    output logic o_cpu_rdata_en,
    output logic o_cpu_wait,
    // Chip enables and buffer control
    output logic o_rom_a_en,
    output logic o_rom_b_en,
    output logic o_rom_c_en,
    output logic o_prn_stat_en,
    output logic o_sysbuf_en,
    output logic o_sysbuf_dir_rd,
    // Dynamic RAM
    output logic [7:0] o_dram_addr,
    output logic o_dram_ras_n,
    output logic [1:0] o_dram_cas_n,
    output logic o_dram_we_n,
    output logic [1:0] o_dram_bank,
    // Keyboard matrix
    output logic [7:0] o_kbd_col,
    input wire logic [7:0] i_kbd_row,
    // Video RAM
    input wire logic [9:0] i_crtc_addr,
    input wire logic i_disp_active,
    output logic [10:0] o_vram_addr,
    output logic [7:0] o_vram_wdata,
    output logic o_vram_we,
    input wire logic [7:0] i_vram_rdata,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import memmap_pkg::*;

    typedef struct packed {
        logic [7:0] krow_a;
        logic [7:0] krow_b;
        logic disp_a;
        logic disp_b;
        logic [7:0] opt;
        ramsize_type size;
        logic io_done;
        dram_state_type dst;
        logic [1:0] dcnt;
        logic mem_done;
        logic vpend;
        logic vwr;
        logic [10:0] vaddr;
        logic [7:0] vdata;
        logic [7:0] rdata;
        logic rdata_en;
        logic wait_o;
        logic rom_a;
        logic rom_b;
        logic rom_c;
        logic prn;
        logic sbuf_en;
        logic sbuf_rd;
        logic [7:0] dadr;
        logic ras_n;
        logic [1:0] cas_n;
        logic we_n;
        logic [1:0] bank;
        logic [7:0] kcol;
        logic [10:0] vram_a;
        logic vram_we;
        logic av_ack;
        logic [31:0] av_rd;
    } state_type;

    state_type s_q;
    state_type s_d;
    target_type tgt;
    map_type map_sel;
    logic [1:0] bank_sel;
    logic mreq;

    // Options selects map and bank table
    function automatic map_type opt_map(input logic [7:0] opt);
        opt_map = map_type'({opt[`OPT_SEL1_BIT], opt[`OPT_SEL0_BIT]});
    endfunction

    // Bank for 32K window: memory bits swap upper half into 128K banks
    function automatic logic [1:0] bank_of(input logic [7:0] opt,
                                           input logic a15);
        logic [1:0] mb;
        mb = {opt[`OPT_MEM1_BIT], opt[`OPT_MEM0_BIT]};
        if (!a15) begin
            bank_of = 2'b00;
        end else if (mb == 2'b00) begin
            bank_of = 2'b01;
        end else begin
            bank_of = mb;
        end
    endfunction

    assign map_sel = opt_map(s_q.opt);
    assign bank_sel = bank_of(s_q.opt, i_cpu_addr[15]);
    assign mreq = i_cpu_mreq && (i_cpu_rd || i_cpu_wr);

    mem_region_decode u_dec (
        .i_addr(i_cpu_addr),
        .i_map(map_sel),
        .i_size(s_q.size),
        .i_rd(i_cpu_rd),
        .o_target(tgt)
    );

    // Next-state logic for the whole block
    always_comb begin
        logic rom;
        logic prn_io;
        logic opt_io;
        rom = 1'b0;
        prn_io = 1'b0;
        opt_io = 1'b0;
        s_d = s_q;
        s_d.krow_a = i_kbd_row;
        s_d.krow_b = s_q.krow_a;
        s_d.disp_a = i_disp_active;
        s_d.disp_b = s_q.disp_a;
        s_d.vram_we = 1'b0;
        s_d.av_ack = 1'b0;
        rom = mreq && (tgt == TGT_ROMA || tgt == TGT_ROMB
                       || tgt == TGT_ROMC);
        prn_io = i_cpu_iorq && i_cpu_rd
                 && i_cpu_addr[7:1] == 7'(`PORT_PRN_BASE >> 1);
        opt_io = i_cpu_iorq && i_cpu_wr
                 && i_cpu_addr[7:2] == 6'(`PORT_OPT_BASE >> 2);
        // Options port write, once per cycle
        if (!i_cpu_iorq) begin
            s_d.io_done = 1'b0;
        end else if (opt_io && !s_q.io_done) begin
            s_d.opt = i_cpu_wdata;
            s_d.io_done = 1'b1;
        end
        // Chip enables and buffer steering
        s_d.rom_a = mreq && tgt == TGT_ROMA;
        s_d.rom_b = mreq && tgt == TGT_ROMB;
        s_d.rom_c = mreq && tgt == TGT_ROMC;
        s_d.prn = (mreq && i_cpu_rd && tgt == TGT_PRN) || prn_io;
        s_d.sbuf_en = (mreq && !rom) || i_cpu_iorq;
        s_d.sbuf_rd = i_cpu_rd;
        // Keyboard columns from low address, rows read back
        s_d.kcol = (mreq && tgt == TGT_KBD) ? i_cpu_addr[7:0]
                                             : 8'h00;
        s_d.rdata_en = 1'b0;
        if (mreq && i_cpu_rd && tgt == TGT_KBD) begin
            s_d.rdata = s_q.krow_b;
            s_d.rdata_en = 1'b1;
        end
        // Dynamic RAM row/column sequencing
        if (!mreq) begin
            s_d.mem_done = 1'b0;
        end
        unique case (s_q.dst)
            DR_IDLE: begin
                s_d.ras_n = 1'b1;
                s_d.cas_n = 2'b11;
                s_d.we_n = 1'b1;
                if (mreq && tgt == TGT_RAM && !s_q.mem_done) begin
                    s_d.dadr = i_cpu_addr[7:0];
                    s_d.bank = bank_sel;
                    s_d.ras_n = 1'b0;
                    s_d.dcnt = 2'(`RAS_CYC);
                    s_d.dst = DR_ROW;
                end
            end
            DR_ROW: begin
                s_d.dcnt = s_q.dcnt - 2'd1;
                if (s_q.dcnt == 2'd1) begin
                    s_d.dadr = {1'b0, i_cpu_addr[14:8]};
                    s_d.dadr[7] = s_q.bank[0];
                    s_d.we_n = !i_cpu_wr;
                    // Row picked by CAS only in 128K
                    s_d.cas_n = (s_q.size == RSZ_128K && s_q.bank[1])
                                ? 2'b01 : 2'b10;
                    s_d.dcnt = 2'(`CAS_CYC);
                    s_d.dst = DR_COL;
                end
            end
            DR_COL: begin
                s_d.dcnt = s_q.dcnt - 2'd1;
                if (s_q.dcnt == 2'd1) begin
                    s_d.mem_done = 1'b1;
                    s_d.dst = DR_IDLE;
                end
            end
            default: begin
                s_d.dst = DR_IDLE;
            end
        endcase
        // Video RAM: processor address muxed with refresh
        s_d.vram_a = {1'b0, i_crtc_addr};
        if (mreq && tgt == TGT_VID && !s_q.mem_done && !s_q.vpend) begin
            s_d.vpend = 1'b1;
            s_d.vwr = i_cpu_wr;
            s_d.vdata = i_cpu_wdata;
            if (map_sel == MAP_III) begin
                s_d.vaddr = i_cpu_addr[10:0];
            end else begin
                s_d.vaddr = {s_q.opt[`OPT_PAGE_BIT],
                             i_cpu_addr[9:0]};
            end
        end
        if (s_q.vpend && !s_q.disp_b) begin
            s_d.vram_a = s_q.vaddr;
            s_d.vram_we = s_q.vwr;
            s_d.vpend = 1'b0;
            s_d.mem_done = 1'b1;
            if (!s_q.vwr) begin
                s_d.rdata = i_vram_rdata;
            end
        end
        if (s_q.mem_done && mreq && i_cpu_rd && tgt == TGT_VID) begin
            s_d.rdata_en = 1'b1;
        end
        s_d.wait_o = (mreq && (tgt == TGT_VID || tgt == TGT_RAM)
                      && !s_d.mem_done);
        // Avalon register access, single-cycle wait
        if ((avs_read || avs_write) && !s_q.av_ack) begin
            s_d.av_ack = 1'b1;
            s_d.av_rd = 32'h0000_0000;
            unique case ({avs_address, 2'b00})
                7'(`OFS_OPTIONS): begin
                    s_d.av_rd = {24'h00_0000, s_q.opt};
                    if (avs_write) begin
                        s_d.opt = avs_writedata[7:0];
                    end
                end
                7'(`OFS_CONFIG): begin
                    s_d.av_rd = {30'h0000_0000, s_q.size};
                    if (avs_write && avs_writedata[1:0] != 2'b11) begin
                        s_d.size = ramsize_type'(avs_writedata[1:0]);
                    end
                end
                7'(`OFS_STATUS): begin
                    s_d.av_rd = {24'h00_0000, 2'b00, s_q.bank, 
                                 2'b00, map_sel};
                end
                7'(`OFS_KEYS_LO): begin
                    s_d.av_rd = {24'h00_0000, s_q.krow_b};
                end
                default: begin
                    s_d.av_rd = 32'h0000_0000;
                end
            endcase
        end
        if (i_rst) begin
            s_d = '0;
            s_d.opt = `OPT_RESET;
            s_d.ras_n = 1'b1;
            s_d.cas_n = 2'b11;
            s_d.we_n = 1'b1;
            s_d.krow_a = 8'hFF;
            s_d.krow_b = 8'hFF;
            s_d.size = RSZ_64K;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        s_q <= s_d;
    end

    assign o_cpu_rdata = s_q.rdata;
    assign o_cpu_rdata_en = s_q.rdata_en;
    assign o_cpu_wait = s_q.wait_o;
    assign o_rom_a_en = s_q.rom_a;
    assign o_rom_b_en = s_q.rom_b;
    assign o_rom_c_en = s_q.rom_c;
    assign o_prn_stat_en = s_q.prn;
    assign o_sysbuf_en = s_q.sbuf_en;
    assign o_sysbuf_dir_rd = s_q.sbuf_rd;
    assign o_dram_addr = s_q.dadr;
    assign o_dram_ras_n = s_q.ras_n;
    assign o_dram_cas_n = s_q.cas_n;
    assign o_dram_we_n = s_q.we_n;
    assign o_dram_bank = s_q.bank;
    assign o_kbd_col = s_q.kcol;
    assign o_vram_addr = s_q.vram_a;
    assign o_vram_wdata = s_q.vdata;
    assign o_vram_we = s_q.vram_we;
    assign avs_readdata = s_q.av_rd;
    assign avs_waitrequest = !s_q.av_ack;

    a_rom_only_map1: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_rom_a_en || o_rom_b_en || o_rom_c_en) |->
        $past(map_sel) == MAP_I)
        else $error("ROM enabled outside compatibility map");
    a_rom_buf_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_rom_a_en || o_rom_b_en || o_rom_c_en) |-> !o_sysbuf_en)
        else $error("Data buffer on during ROM access");
    a_roma_range: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (mreq && map_sel == MAP_I && i_cpu_addr <= 16'h1FFF)
        |=> o_rom_a_en)
        else $error("ROM A not selected");
    a_prn_io: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_cpu_iorq && i_cpu_rd && i_cpu_addr[7:1] == 7'h7C)
        |=> o_prn_stat_en)
        else $error("Printer status not enabled for port read");
    a_map4_ram: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (map_sel == MAP_IV) |-> tgt == TGT_RAM)
        else $error("Map IV not all RAM");
    a_map3_kbd: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (map_sel == MAP_III && i_cpu_addr[15:10] == 6'h3D)
        |-> tgt == TGT_KBD)
        else $error("Map III keyboard window wrong");
    a_kbd_col: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (mreq && tgt == TGT_KBD) |=> o_kbd_col == $past(i_cpu_addr[7:0]))
        else $error("Keyboard column not from address");
    a_cas_one_row: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_dram_cas_n != 2'b00)
        else $error("Both RAM rows strobed");
    a_vid_wait: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (s_q.vpend && s_q.disp_b) |=> o_vram_we == 1'b0)
        else $error("Video write during active display");
    a_reset_map: assert property (@(posedge i_clk_sys)
        ($past(i_rst) && !i_rst)
        |-> map_sel == MAP_I && s_q.opt == 8'h00)
        else $error("Reset map not compatibility");
endmodule
`default_nettype wire

// ===== test/cpu_bus_model.sv
// Processor bus model: memory and port cycles held until wait drops
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_io,
    input wire logic i_wr,
    input wire logic [15:0] i_adr,
    input wire logic [7:0] i_dat,
    input wire logic i_wait,
    input wire logic [37:0] i_obs,
    output logic o_done,
    output logic [37:0] o_obs,
    output logic [15:0] o_adr,
    output logic [7:0] o_dat,
    output logic o_mreq,
    output logic o_iorq,
    output logic o_rd,
    output logic o_wr
);
    logic busy_q;
    int n = 0;
    // Idle bus at time zero
    initial {o_adr, o_dat, o_mreq, o_iorq, o_rd, o_wr, o_done, busy_q} = '0;
    // Raise a request, hold it until wait is seen low, then release
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        if (i_rst || (busy_q && n >= 1 && !i_wait)) begin
            o_done <= !i_rst;
            o_obs <= i_obs;
            busy_q <= 1'b0;
            {o_mreq, o_iorq, o_rd, o_wr} <= 4'h0;
            o_adr <= ~o_adr;  // Released lines never keep the last value
            o_dat <= ~o_dat;
        end else if (busy_q) begin
            n <= n + 1;
        end else if (i_go) begin
            busy_q <= 1'b1;
            n <= 0;
            o_adr <= i_adr;
            o_dat <= i_wr ? i_dat : ~o_dat;
            {o_mreq, o_iorq} <= {!i_io, i_io};
            {o_rd, o_wr} <= {!i_wr, i_wr};
        end
    end
endmodule
`default_nettype wire

// ===== test/memory_map_decoder_tb.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/10ps
`default_nettype none
module memory_map_decoder_tb;
    import memmap_pkg::*;
    typedef struct {
        logic [37:0] v;
        logic [37:0] m;
    } exp_type;
    localparam logic [15:0] edge_adr [20] = '{16'h0000, 16'h1FFF, 16'h2000,
        16'h2FFF, 16'h3000, 16'h37E8, 16'h37E9, 16'h37FF, 16'h3800, 16'h3BFF,
        16'h3C00, 16'h3FFF, 16'h4000, 16'h7FFF, 16'h8000, 16'hF3FF, 16'hF400,
        16'hF7FF, 16'hF800, 16'hFFFF};
    logic clk = 1'b0, rst = 1'b1, go = 1'b0, c_io = 1'b0, c_wr = 1'b0;
    logic disp = 1'b0, av_rd = 1'b0, av_wr = 1'b0, page_s = 1'b0;
    logic mreq, iorq, rd, wr, rdata_en, cpu_wait, rom_a, rom_b, rom_c, prn;
    logic sysbuf, sysdir, ras_n, we_n, vram_we, av_wait, c_done;
    logic [1:0] cas_n, bank, map_s = 2'h0, mem_s = 2'h0, size_s = 2'h1;
    logic [4:0] av_adr = 5'h00;
    logic [7:0] kbd_row = 8'hFF, vram_rdata = 8'h3C, c_dat = 8'h00;
    logic [7:0] cpu_wdata, cpu_rdata, kbd_col, vram_wdata, dram_addr;
    logic [9:0] crtc = 10'h155;
    logic [10:0] vram_addr;
    logic [15:0] c_adr = 16'h0000, cpu_addr;
    logic [31:0] av_wd = 32'h0, av_rdata;
    logic [37:0] obs, c_obs;
    int n_errors = 0, comparisons = 0, n_done = 0, cyc = 0;
    exp_type cq[$], aq[$];

    memory_map_decoder memory_map_decoder_inst (
        .i_clk_sys(clk), .i_rst(rst), .i_cpu_addr(cpu_addr),
        .i_cpu_wdata(cpu_wdata), .i_cpu_mreq(mreq), .i_cpu_iorq(iorq),
        .i_cpu_rd(rd), .i_cpu_wr(wr), .o_cpu_rdata(cpu_rdata),
        .o_cpu_rdata_en(rdata_en), .o_cpu_wait(cpu_wait),
        .o_rom_a_en(rom_a), .o_rom_b_en(rom_b), .o_rom_c_en(rom_c),
        .o_prn_stat_en(prn), .o_sysbuf_en(sysbuf), .o_sysbuf_dir_rd(sysdir),
        .o_dram_addr(dram_addr), .o_dram_ras_n(ras_n), .o_dram_cas_n(cas_n),
        .o_dram_we_n(we_n), .o_dram_bank(bank), .o_kbd_col(kbd_col),
        .i_kbd_row(kbd_row), .i_crtc_addr(crtc), .i_disp_active(disp),
        .o_vram_addr(vram_addr), .o_vram_wdata(vram_wdata),
        .o_vram_we(vram_we), .i_vram_rdata(vram_rdata),
        .avs_address(av_adr), .avs_read(av_rd), .avs_write(av_wr),
        .avs_writedata(av_wd), .avs_readdata(av_rdata),
        .avs_waitrequest(av_wait));

    cpu_bus_model cpu_bus_model_inst (
        .i_clk(clk), .i_rst(rst), .i_go(go), .i_io(c_io), .i_wr(c_wr),
        .i_adr(c_adr), .i_dat(c_dat), .i_wait(cpu_wait), .i_obs(obs),
        .o_done(c_done), .o_obs(c_obs), .o_adr(cpu_addr), .o_dat(cpu_wdata),
        .o_mreq(mreq), .o_iorq(iorq), .o_rd(rd), .o_wr(wr));

    // Decoder outputs gathered for the bus model to capture
    assign obs = {rom_a, rom_b, rom_c, prn, sysbuf, rdata_en, ras_n, cas_n,
        bank, kbd_col, cpu_rdata, vram_addr};

    always #2.5 clk = ~clk;

    // Cycle ceiling well above the length of the whole sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            results();
        end
    end

    // Match each observed result with the oldest expectation
    always @(posedge clk) begin
        exp_type e;
        if (c_done === 1'b1) begin
            n_done = n_done + 1;
            e = cq.pop_front();
            chk("cpu", c_obs & e.m, e.v & e.m);
        end
        if (av_rd && av_wait === 1'b0) begin
            e = aq.pop_front();
            chk("avs", {6'h00, av_rdata} & e.m, e.v & e.m);
        end
    end

    task automatic chk(input string s, input logic [37:0] sn,
                       input logic [37:0] xv);
        comparisons++;
        if (sn !== xv) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", s, xv, sn);
        end
    endtask

    task automatic results();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One register bus transfer, held until waitrequest is sampled low
    task automatic av(input logic w, input logic [4:0] i,
                      input logic [31:0] d, input logic [31:0] m);
        int k;
        exp_type e;
        e.v = {6'h00, d};
        e.m = {6'h00, m};
        if (!w)
            aq.push_back(e);
        @(posedge clk);
        av_adr <= i;
        av_wd <= d;
        {av_rd, av_wr} <= {!w, w};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (av_wait !== 1'b0 && k < 200);
        {av_rd, av_wr} <= 2'h0;
        if (k == 200)
            n_errors++;
    endtask

    // One processor cycle through the bus model
    task automatic cpu(input logic io, input logic w, input logic [15:0] a,
                       input logic [7:0] d, input exp_type e);
        int k;
        cq.push_back(e);
        @(posedge clk);
        {go, c_io, c_wr, c_adr, c_dat} <= {1'b1, io, w, a, d};
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (c_done !== 1'b1 && k < 400);
        if (k == 400)
            n_errors++;
    endtask

    // Expected decode of one memory read under the current settings
    function automatic exp_type ex(input logic [15:0] a);
        exp_type e;
        target_type t;
        logic [1:0] bk;
        logic r, k, rom, big;
        case (map_s)
            MAP_I: t = a <= 16'h1FFF ? TGT_ROMA : a <= 16'h2FFF ? TGT_ROMB :
                (a == 16'h37E8 || a == 16'h37E9) ? TGT_PRN :
                a <= 16'h37FF ? TGT_ROMC : a <= 16'h3BFF ? TGT_KBD :
                a <= 16'h3FFF ? TGT_VID :
                (size_s == RSZ_16K && a[15]) ? TGT_NONE : TGT_RAM;
            MAP_II: t = a <= 16'h37FF ? TGT_RAM : a <= 16'h3BFF ? TGT_KBD :
                a <= 16'h3FFF ? TGT_VID : TGT_RAM;
            MAP_III: t = a <= 16'hF3FF ? TGT_RAM :
                a <= 16'hF7FF ? TGT_KBD : TGT_VID;
            default: t = TGT_RAM;
        endcase
        r = t == TGT_RAM;
        k = t == TGT_KBD;
        rom = t inside {TGT_ROMA, TGT_ROMB, TGT_ROMC};
        big = r && size_s == RSZ_128K;
        bk = !a[15] ? 2'h0 : mem_s == 2'h0 ? 2'h1 : mem_s;
        e.v = {t == TGT_ROMA, t == TGT_ROMB, t == TGT_ROMC, t == TGT_PRN,
            !rom, k, !r, bk[1] ? 2'h1 : 2'h2, bk, k ? a[7:0] : 8'h00,
            kbd_row, map_s == MAP_III ? a[10:0] : {page_s, a[9:0]}};
        e.m = {4'hF, rom || r, rom || k, 1'b1, {4{big}}, 8'hFF, {8{k}},
            {11{t == TGT_VID}}};
        return e;
    endfunction

    // Options write and map readback over the register bus
    task automatic opt(input logic [1:0] m, input logic [1:0] b,
                       input logic p);
        map_s = m;
        mem_s = b;
        page_s = p;
        av(1'b1, 5'h00, {24'h00_0000, p, 1'b0, b, 2'h0, m}, 32'h0);
        av(1'b0, 5'h02, {30'h0, m}, 32'h3);
    endtask

    // Main sequence
    initial begin
        logic [15:0] a;
        int s;
        s = $urandom(32'h3b45_4fc3);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        av(1'b0, 5'h00, 32'h0, 32'hFF);
        av(1'b0, 5'h01, 32'h1, 32'h3);
        av(1'b0, 5'h02, 32'h0, 32'h3);
        av(1'b1, 5'h07, 32'hFFFF_FFFF, 32'h0);
        av(1'b0, 5'h07, 32'h0, 32'hFFFF_FFFF);
        av(1'b1, 5'h01, 32'h3, 32'h0);
        av(1'b0, 5'h01, 32'h1, 32'h3);
        kbd_row <= 8'($urandom);
        repeat (4) @(posedge clk);
        av(1'b0, 5'h03, {24'h00_0000, kbd_row}, 32'hFF);
        // Every map and bank setting for 64K and 128K, 16K in map I bank 0 only, across all region edges
        for (int z = 0; z < 3; z++) begin
            size_s = 2'(z);
            av(1'b1, 5'h01, 32'(z), 32'h0);
            for (int m = 0; m < 16; m++) begin
                if (z == 0 && m != 0)
                    continue;
                opt(2'(m), 2'(m >> 2), 1'($urandom));
                kbd_row <= 8'($urandom);
                repeat (4) @(posedge clk);
                for (int j = 0; j < 21; j++) begin
                    a = j < 20 ? edge_adr[j] : 16'($urandom);
                    cpu(1'b0, 1'b0, a, 8'h00, ex(a));
                end
                cpu(1'b0, 1'b1, a, 8'($urandom), '{38'h0, 38'h0});
            end
        end
        // Options through the port space, then a printer status input
        cpu(1'b1, 1'b1, 16'h0086, 8'h93, '{38'h0, 38'h0});
        av(1'b0, 5'h00, 32'h93, 32'hFF);
        av(1'b0, 5'h02, 32'h3, 32'h3);
        cpu(1'b1, 1'b0, 16'h00F9, 8'h00, '{{4'h1, 34'h0}, {4'hF, 34'h0}});
        // Video read held off while the display is active
        opt(2'h0, 2'h0, 1'b1);
        disp <= 1'b1;
        s = n_done;
        fork
            cpu(1'b0, 1'b0, 16'h3C05, 8'h00, ex(16'h3C05));
            begin
                repeat (30) @(posedge clk);
                chk("vwait", 38'(n_done), 38'(s));
                disp <= 1'b0;
            end
        join
        // Reset in mid-run returns to the first map
        opt(2'h3, 2'h2, 1'b1);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        {map_s, mem_s, page_s, size_s} = 7'h01;
        av(1'b0, 5'h00, 32'h0, 32'hFF);
        cpu(1'b0, 1'b0, 16'h0100, 8'h00, ex(16'h0100));
        results();
    end
endmodule
`default_nettype wire
